// file: clock_reset_pkg.sv
// constants, register map and carriers for the clock and reset front end
package clock_reset_pkg;

  // ---------------------------------------------------------------------
  // apb register map (byte addresses)
  // ---------------------------------------------------------------------
  localparam logic [7:0]  CTRL_OFFSET      = 8'h00;
  localparam logic [7:0]  STATUS_OFFSET    = 8'h04;
  localparam logic [7:0]  REF_PERIOD_OFFSET = 8'h08;
  localparam logic [7:0]  TICK_COUNT_OFFSET = 8'h0c;

  // control register fields and reset value
  localparam int          CTRL_CLK_GATE_BIT = 0;
  localparam int          CTRL_SDRAM_GATE_BIT = 1;
  localparam logic [1:0]  CTRL_RESET_VALUE  = 2'h3;

  // ---------------------------------------------------------------------
  // pll model and reset filter figures
  // ---------------------------------------------------------------------
  localparam int          MULT_W            = 8;
  localparam logic [7:0]  MULT_NORMAL_X10   = 8'h32;  // factor 5.0 in tenths
  localparam logic [7:0]  MULT_TEST_X10     = 8'h42;  // factor 6.6 in tenths
  localparam logic [7:0]  MULT_SCALE        = 8'h0a;  // tenths per unit
  localparam int          PERIOD_W          = 16;
  localparam int          RESET_FILTER_LEN  = 64;     // master clock cycles

  // ---------------------------------------------------------------------
  // status word carried to the register file
  // ---------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] pll_multiplier;
    logic       internal_reset;
    logic       test_reset;
    logic       chip_test_mode;
    logic       clock_source_select;
    logic       clock_out_driven;
  } status_s;

  localparam int          STATUS_W          = $bits(status_s);

endpackage

// file: rate_synth.sv
// pll stand-in: measures the reference period and emits master clock ticks
`timescale 1ns/1ps
`default_nettype none
module rate_synth
  import clock_reset_pkg::*;
#(
  parameter int PW = PERIOD_W
)
(
  // clock and reset
  input  wire logic          pclk,
  input  wire logic          presetn,
  // reference clock and factor
  input  wire logic          ref_edge,
  input  wire logic [7:0]    mult_x10,
  // results
  output logic               tick,
  output logic [PW-1:0]      period
);

  logic [PW-1:0]   count_q;
  logic [PW-1:0]   period_q;
  logic [PW+3:0]   acc_q;
  logic            tick_q;
  wire  [PW+3:0]   limit   = {period_q, 4'h0} - {2'h0, period_q, 2'h0} - {3'h0, period_q, 1'h0};
  wire  [PW+3:0]   acc_sum = acc_q + {{(PW-4){1'b0}}, mult_x10};
  wire             wrap    = (period_q != '0) && (acc_sum >= limit);

  // reference period in pclk cycles, caught at each reference edge
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      count_q  <= '0;
      period_q <= '0;
    end
    else if (ref_edge)
    begin
      count_q  <= {{(PW-1){1'b0}}, 1'b1};
      period_q <= count_q;
    end
    else if (count_q != '1)
      count_q <= count_q + 1'b1;
  end

  // phase accumulator: mult_x10 tenths of a tick per reference period
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      acc_q  <= '0;
      tick_q <= 1'b0;
    end
    else
    begin
      acc_q  <= wrap ? acc_sum - limit : acc_sum;
      tick_q <= wrap;
    end
  end

  assign tick   = tick_q;
  assign period = period_q;

endmodule
`default_nettype wire

// file: reset_filter.sv
// digital filter on the global reset pin, counted in master clock ticks
`timescale 1ns/1ps
`default_nettype none
module reset_filter
  import clock_reset_pkg::*;
#(
  parameter int LEN = RESET_FILTER_LEN
)
(
  // clock and reset
  input  wire logic  pclk,
  input  wire logic  presetn,
  // master clock tick and pin level
  input  wire logic  tick,
  input  wire logic  pin_n,
  // filtered reset, active high
  output logic       reset_active
);

  logic [$clog2(LEN+1)-1:0] low_q;
  logic                     active_q;
  wire                      full = (low_q == ($clog2(LEN+1))'(LEN - 1));

  // count low ticks, short pulses never reach the end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      low_q    <= '0;
      active_q <= 1'b1;
    end
    else if (tick)
    begin
      if (pin_n)
      begin
        low_q    <= '0;
        active_q <= 1'b0;  // release on a master tick
      end
      else if (full)
        active_q <= 1'b1;
      else
        low_q <= low_q + 1'b1;
    end
  end

  assign reset_active = active_q;

endmodule
`default_nettype wire

// file: clock_reset_select.sv
// clock source select, clock output, reset filter and apb register file
`timescale 1ns/1ps
`default_nettype none
module clock_reset_select
  import clock_reset_pkg::*;
#(
  parameter int FILTER_LEN = RESET_FILTER_LEN,
  parameter int PW         = PERIOD_W
)
(
  // clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // apb slave
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [7:0]   paddr,
  input  wire logic [31:0]  pwdata,
  output logic [31:0]       prdata,
  output logic              pready,
  output logic              pslverr,
  // board pins
  input  wire logic         ext_clock_in,
  input  wire logic         clock_source_select,
  input  wire logic         global_reset_n,
  input  wire logic         clock_out_enable,
  input  wire logic         test_mode_pin,
  input  wire logic         test_logic_reset_n,
  // clock outputs
  output logic              system_clock_out,
  output logic              system_clock_out_oe_n,
  output logic              sdram_clock,
  // chip side
  output logic              master_tick,
  output logic              internal_reset_n,
  output logic              test_reset_n,
  output logic              chip_test_mode,
  output logic [7:0]        pll_multiplier
);

  // ---------------------------------------------------------------------
  // reference edge detection
  // ---------------------------------------------------------------------
  logic        ext_q;
  wire         ext_rise = ext_clock_in & ~ext_q;

  // previous level of the external clock
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ext_q <= 1'b0;
    else
      ext_q <= ext_clock_in;
  end

  // ---------------------------------------------------------------------
  // multiplication factor and test mode
  // ---------------------------------------------------------------------
  logic [7:0]  mult_q;
  logic        test_mode_q;
  wire  [7:0]  mult_d = test_mode_pin ? MULT_TEST_X10 : MULT_NORMAL_X10;

  // factor follows the pin, registered for the outputs
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mult_q      <= MULT_NORMAL_X10;
      test_mode_q <= 1'b0;
    end
    else
    begin
      mult_q      <= mult_d;
      test_mode_q <= test_mode_pin;
    end
  end

  // ---------------------------------------------------------------------
  // pll model and source selection
  // ---------------------------------------------------------------------
  wire          pll_tick;
  wire [PW-1:0] ref_period;

  // ticks at mult/10 times the reference rate
  rate_synth #(
    .PW       (PW)
  ) u_pll (
    .pclk     (pclk),
    .presetn  (presetn),
    .ref_edge (ext_rise),
    .mult_x10 (mult_d),
    .tick     (pll_tick),
    .period   (ref_period)
  );

  // pll or external clock as master clock
  wire          sel_tick = clock_source_select ? ext_rise : pll_tick;

  logic         tick_q;
  logic [31:0]  tick_count_q;

  // registered master tick and a running count of master cycles
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tick_q       <= 1'b0;
      tick_count_q <= '0;
    end
    else
    begin
      tick_q <= sel_tick;
      if (sel_tick)
        tick_count_q <= tick_count_q + 32'h1;
    end
  end

  // ---------------------------------------------------------------------
  // reset filter and synchronous release
  // ---------------------------------------------------------------------
  wire          filt_active;
  logic         int_rst_n_q;

  // low level must last the whole filter length
  reset_filter #(
    .LEN          (FILTER_LEN)
  ) u_filter (
    .pclk         (pclk),
    .presetn      (presetn),
    .tick         (sel_tick),
    .pin_n        (global_reset_n),
    .reset_active (filt_active)
  );

  // release follows the registered master tick by one cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      int_rst_n_q <= 1'b0;
    else
      int_rst_n_q <= ~filt_active;
  end

  // ---------------------------------------------------------------------
  // test logic reset: asynchronous assertion
  // ---------------------------------------------------------------------
  logic         test_rst_n_q;
  wire          test_clr_n = test_logic_reset_n & presetn;

  // no test clock needed to enter reset
  always_ff @(posedge pclk or negedge test_clr_n)
  begin
    if (!test_clr_n)
      test_rst_n_q <= 1'b0;
    else
      test_rst_n_q <= 1'b1;
  end

  // ---------------------------------------------------------------------
  // apb register file
  // ---------------------------------------------------------------------
  logic [1:0]   ctrl_q;
  logic [31:0]  prdata_q;
  logic         pready_q;
  logic         pslverr_q;
  status_s      status;

  wire          setup     = psel & ~penable;
  wire          access    = psel & penable & pready_q;
  wire          hit_ctrl  = (paddr == CTRL_OFFSET);
  wire          hit_stat  = (paddr == STATUS_OFFSET);
  wire          hit_per   = (paddr == REF_PERIOD_OFFSET);
  wire          hit_tick  = (paddr == TICK_COUNT_OFFSET);
  wire          mapped    = hit_ctrl | hit_stat | hit_per | hit_tick;
  wire          wr_ctrl   = access & pwrite & hit_ctrl;

  // status snapshot from block state
  assign status.pll_multiplier      = mult_q;
  assign status.internal_reset      = ~int_rst_n_q;
  assign status.test_reset          = ~test_rst_n_q;
  assign status.chip_test_mode      = test_mode_q;
  assign status.clock_source_select = clock_source_select;
  assign status.clock_out_driven    = ~system_clock_out_oe_n;

  // read mux, unmapped addresses read zero
  wire  [31:0]  rd_mux =
    hit_ctrl ? {30'h0, ctrl_q} :
    hit_stat ? {{(32-STATUS_W){1'b0}}, status} :
    hit_per  ? {{(32-PW){1'b0}}, ref_period} :
    hit_tick ? tick_count_q : 32'h0;

  // one wait-free answer: ready in the first access cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= '0;
    end
    else
    begin
      pready_q  <= setup;
      pslverr_q <= setup & ~mapped;
      if (setup && !pwrite)
        prdata_q <= rd_mux;
    end
  end

  // control register: software gates on the clock outputs
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl_q <= CTRL_RESET_VALUE;
    else if (wr_ctrl)
      ctrl_q <= pwdata[1:0];
  end

  // ---------------------------------------------------------------------
  // clock outputs
  // ---------------------------------------------------------------------
  logic         clk_out_q;
  logic         sdram_q;
  logic         oe_n_q;
  logic         half_q;

  // square wave from master ticks, two cycles behind the tick
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      half_q    <= 1'b0;
      clk_out_q <= 1'b0;
      sdram_q   <= 1'b0;
      oe_n_q    <= 1'b1;
    end
    else
    begin
      if (tick_q)
        half_q <= ~half_q;
      clk_out_q <= half_q;
      sdram_q   <= half_q & ctrl_q[CTRL_SDRAM_GATE_BIT];
      oe_n_q    <= ~(clock_out_enable & ctrl_q[CTRL_CLK_GATE_BIT]);
    end
  end

  // ---------------------------------------------------------------------
  // output drive
  // ---------------------------------------------------------------------
  assign prdata                = prdata_q;
  assign pready                = pready_q;
  assign pslverr               = pslverr_q;
  assign system_clock_out      = clk_out_q;
  assign system_clock_out_oe_n = oe_n_q;
  assign sdram_clock           = sdram_q;
  assign master_tick           = tick_q;
  assign internal_reset_n      = int_rst_n_q;
  assign test_reset_n          = test_rst_n_q;
  assign chip_test_mode        = test_mode_q;
  assign pll_multiplier        = mult_q;

endmodule
`default_nettype wire

// file: clock_reset_select_asserts.sv
// concurrent checks on the clock and reset front end ports
`timescale 1ns/1ps
`default_nettype none
module clock_reset_select_asserts
  import clock_reset_pkg::*;
#(
  parameter int FILTER_LEN = RESET_FILTER_LEN
)
(
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // board pins
  input  wire logic       ext_clock_in,
  input  wire logic       clock_source_select,
  input  wire logic       global_reset_n,
  input  wire logic       clock_out_enable,
  input  wire logic       test_mode_pin,
  input  wire logic       test_logic_reset_n,
  // chip outputs
  input  wire logic       system_clock_out,
  input  wire logic       system_clock_out_oe_n,
  input  wire logic       master_tick,
  input  wire logic       internal_reset_n,
  input  wire logic       test_reset_n,
  input  wire logic       chip_test_mode,
  input  wire logic [7:0] pll_multiplier
);
  default clocking cb @(posedge pclk);
  endclocking
  // --------
  // master ticks that saw the reset pin low, saturating; warm-up after reset
  // --------
  logic        pin_q;
  logic [15:0] low_q;
  logic [1:0]  live_q;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      pin_q  <= 1'b1;
      low_q  <= 16'h0000;
      live_q <= 2'b00;
    end
    else
    begin
      pin_q  <= global_reset_n;
      live_q <= {live_q[0], 1'b1};
      if (master_tick)
        low_q <= pin_q ? 16'h0000 : low_q + {15'h0000, ~&low_q};
    end
  // checks start once two post-reset samples exist
  default disable iff (!presetn || !live_q[1]);
  // --------
  // properties
  // --------
  a_ext_tick: assert property (
    $rose(ext_clock_in) && clock_source_select |-> ##[1:2] master_tick)
    else $error("no master tick after external edge");
  a_tick_pulse: assert property (master_tick |=> !master_tick)
    else $error("master tick longer than one cycle");
  a_test_mult: assert property (test_mode_pin [*2] |-> pll_multiplier == MULT_TEST_X10)
    else $error("multiplier wrong in test mode");
  a_test_mode: assert property (1'b1 |=> chip_test_mode == $past(test_mode_pin))
    else $error("chip test mode not following pin");
  a_oe_off: assert property (!clock_out_enable |=> system_clock_out_oe_n)
    else $error("clock output driven while disabled");
  a_sclk_tick: assert property ($changed(system_clock_out) |-> $past(master_tick, 2))
    else $error("clock output moved without a master tick");
  a_trst_async: assert property (!test_logic_reset_n |-> !test_reset_n)
    else $error("test reset not asserted");
  a_filter_len: assert property ($fell(internal_reset_n) |-> low_q >= FILTER_LEN)
    else $error("reset taken from a short low pulse");
  c_ext_tick: cover property (master_tick && clock_source_select);
  c_filtered: cover property ($fell(internal_reset_n));
  c_driven: cover property (!system_clock_out_oe_n && test_mode_pin);
endmodule

bind clock_reset_select clock_reset_select_asserts #(.FILTER_LEN(FILTER_LEN)) chk_u (
  .pclk(pclk), .presetn(presetn), .ext_clock_in(ext_clock_in),
  .clock_source_select(clock_source_select), .global_reset_n(global_reset_n),
  .clock_out_enable(clock_out_enable), .test_mode_pin(test_mode_pin),
  .test_logic_reset_n(test_logic_reset_n), .system_clock_out(system_clock_out),
  .system_clock_out_oe_n(system_clock_out_oe_n), .master_tick(master_tick),
  .internal_reset_n(internal_reset_n), .test_reset_n(test_reset_n),
  .chip_test_mode(chip_test_mode), .pll_multiplier(pll_multiplier));
`default_nettype wire

// file: board_model.sv
// board reference clock and global reset pin driver
`timescale 1ns/1ps
`default_nettype none
module board_model
(
  // clock and controls
  input  wire logic       pclk,
  input  wire logic       run,
  input  wire logic [7:0] half,
  // board pins
  output var logic        ext_clock_in,
  output var logic        global_reset_n
);
  logic [7:0] cnt_q;
  initial
  begin
    cnt_q = 8'h00;
    ext_clock_in = 1'b0;
    global_reset_n = 1'b1;
  end
  // reference clock, standing low while stopped
  always @(posedge pclk)
  begin
    cnt_q <= (cnt_q + 8'h01 >= half || !run) ? 8'h00 : cnt_q + 8'h01;
    ext_clock_in <= run && (cnt_q + 8'h01 >= half) ? !ext_clock_in : run && ext_clock_in;
  end
  // hold the reset pin low across n reference rises
  task automatic hold_reset(input int n);
    global_reset_n <= 1'b0;
    repeat (n) @(posedge ext_clock_in);
    @(posedge pclk);
    global_reset_n <= 1'b1;
  endtask
endmodule
`default_nettype wire

// file: tb.sv
// self-checking bench for the clock and reset front end
`timescale 1ns/1ps
`default_nettype none
module tb;
  import clock_reset_pkg::*;
  localparam int FL = 8;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00, half = 8'h03, pll_multiplier;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, err, run = 1'b0, clock_source_select = 1'b1;
  logic        clock_out_enable = 1'b0, test_mode_pin = 1'b0, test_logic_reset_n = 1'b1;
  logic        ext_clock_in, global_reset_n, system_clock_out, system_clock_out_oe_n;
  logic        sdram_clock, master_tick, internal_reset_n, test_reset_n, chip_test_mode;
  int          fails = 0, cmp_count = 0, seed = 32'hdb81;
  int          ticks = 0, rises = 0, lows = 0, t0, r0, c0, v;
  int          togs = 0, g0;
  logic        so_q = 1'b0;
  int          exp_q[$];
  clock_reset_select #(.FILTER_LEN(FL)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_clock_in(ext_clock_in), .clock_source_select(clock_source_select),
    .global_reset_n(global_reset_n), .clock_out_enable(clock_out_enable),
    .test_mode_pin(test_mode_pin), .test_logic_reset_n(test_logic_reset_n),
    .system_clock_out(system_clock_out), .system_clock_out_oe_n(system_clock_out_oe_n),
    .sdram_clock(sdram_clock), .master_tick(master_tick),
    .internal_reset_n(internal_reset_n), .test_reset_n(test_reset_n),
    .chip_test_mode(chip_test_mode), .pll_multiplier(pll_multiplier));
  board_model brd_u (.pclk(pclk), .run(run), .half(half), .ext_clock_in(ext_clock_in),
    .global_reset_n(global_reset_n));
  always #2.5 pclk = ~pclk;
  // model counters: master ticks, reference rises, filtered reset cycles
  always @(posedge pclk) ticks <= ticks + (master_tick === 1'b1);
  always @(posedge pclk) lows <= lows + (presetn && internal_reset_n === 1'b0);
  always @(posedge ext_clock_in) rises <= rises + 1;
  // clock output edges, one per master tick
  always @(posedge pclk) togs <= togs + (system_clock_out !== so_q);
  always @(posedge pclk) so_q <= system_clock_out;
  // --------
  // checks and bus cycles
  // --------
  task automatic tally_and_finish;
    if (fails == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chkr(input int got, input int lo, input int hi);
    cmp_count++;
    if (got < lo || got > hi)
    begin
      fails++;
      $display("wrong value at %0t: got %h expected %h to %h", $time, got, lo, hi);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n == 0 || pready !== 1'b1; n++)
    begin
      if (n == 20)
      begin
        fails++;
        tally_and_finish();
      end
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wait_irst(input logic lvl);
    int n;
    for (n = 0; internal_reset_n !== lvl; n++)
    begin
      if (n == 3000)
      begin
        fails++;
        tally_and_finish();
      end
      @(posedge pclk);
    end
  endtask
  // --------
  // main sequence
  // --------
  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    run <= 1'b1;
    wait_irst(1'b1);
    apb(1'b1, 8'h10, 32'hffff_ffff);
    chk(err, 1'b1);
    apb(1'b0, 8'h10, 32'h0);
    chk({rd[30:0], err}, 32'h1);
    repeat (8)
    begin
      v = $random(seed);
      clock_out_enable <= v[4];
      apb(1'b1, CTRL_OFFSET, v);
      exp_q.push_back(v & 3);
      apb(1'b0, CTRL_OFFSET, 32'h0);
      chk(rd, exp_q.pop_front());
      chk(system_clock_out_oe_n, !(v[4] && v[0]));
    end
    apb(1'b1, CTRL_OFFSET, 32'h3);
    clock_out_enable <= 1'b1;
    run <= 1'b0;
    repeat (8) @(posedge pclk);
    apb(1'b0, TICK_COUNT_OFFSET, 32'h0);
    c0 = rd;
    t0 = ticks;
    r0 = rises;
    g0 = togs;
    run <= 1'b1;
    repeat (120)
    begin
      @(posedge pclk);
      chk(sdram_clock, system_clock_out);
    end
    run <= 1'b0;
    repeat (8) @(posedge pclk);
    chkr(rises - r0, 19, 21);
    chk(ticks - t0, rises - r0);
    chk(togs - g0, ticks - t0);
    apb(1'b0, TICK_COUNT_OFFSET, 32'h0);
    chk(rd - c0, ticks - t0);
    half <= 8'h1e;
    run <= 1'b1;
    repeat (120) @(posedge pclk);
    // slow reference measured before the pll takes over
    clock_source_select <= 1'b0;
    repeat (300) @(posedge pclk);
    apb(1'b0, REF_PERIOD_OFFSET, 32'h0);
    chk(rd, 32'd60);
    for (v = 0; v < 2; v++)
    begin
      test_mode_pin <= v[0];
      repeat (300) @(posedge pclk);
      t0 = ticks;
      repeat (600) @(posedge pclk);
      chkr(ticks - t0, v ? 65 : 49, v ? 67 : 51);
      chk(pll_multiplier, v ? MULT_TEST_X10 : MULT_NORMAL_X10);
      chk(chip_test_mode, v[0]);
      apb(1'b0, STATUS_OFFSET, 32'h0);
      chk({rd[12:5], rd[2]}, {(v ? 8'h42 : 8'h32), v[0]});
    end
    test_mode_pin <= 1'b0;
    clock_source_select <= 1'b1;
    half <= 8'h03;
    repeat (20) @(posedge pclk);
    t0 = lows;
    brd_u.hold_reset(FL - 3);
    repeat (20) @(posedge pclk);
    chk(lows - t0, 0);
    brd_u.hold_reset(FL + 2);
    wait_irst(1'b1);
    chkr(lows - t0, 1, 100);
    test_logic_reset_n <= 1'b0;
    #1;
    chk(test_reset_n, 1'b0);
    @(posedge pclk);
    test_logic_reset_n <= 1'b1;
    repeat (3) @(posedge pclk);
    chk(test_reset_n, 1'b1);
    apb(1'b1, CTRL_OFFSET, 32'h0);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    chk(internal_reset_n, 1'b0);
    wait_irst(1'b1);
    apb(1'b0, CTRL_OFFSET, 32'h0);
    chk(rd, CTRL_RESET_VALUE);
    tally_and_finish();
  end
endmodule
`default_nettype wire
